// ### rtl/dcm_pkg.sv
package dcm_pkg;
  // operation codes from the load/store pipeline
  localparam logic [3:0] OP_ALLOC = 4'h0;
  localparam logic [3:0] OP_FLUSH = 4'h1;
  localparam logic [3:0] OP_INVAL = 4'h2;
  localparam logic [3:0] OP_STORE = 4'h3;
  localparam logic [3:0] OP_TOUCH = 4'h4;
  localparam logic [3:0] OP_TOUCH_ST = 4'h5;
  localparam logic [3:0] OP_ZERO = 4'h6;
  localparam logic [3:0] OP_FLASH_INVAL = 4'h7;
  localparam logic [3:0] OP_DEBUG_READ = 4'h8;
  // write-back request sizes
  localparam logic [1:0] WB_DWORD = 2'h0;
  localparam logic [1:0] WB_QWORD = 2'h1;
  localparam logic [1:0] WB_LINE = 2'h2;
  // line geometry
  localparam int DWORDS_PER_LINE = 4;
  localparam int WORDS_PER_LINE = 8;
  localparam int LINE_BYTES = 32;
  localparam int LINE_BITS = 256;
  localparam int TAG_BITS = 28;
  // register offsets
  localparam logic [3:0] ADDR_CFG_A = 4'h0;
  localparam logic [3:0] ADDR_CFG_B = 4'h1;
  localparam logic [3:0] ADDR_TAG_HIGH = 4'h2;
  localparam logic [3:0] ADDR_TAG_LOW = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // configuration bit positions
  localparam int CFG_A_GTOUCH = 0;
  localparam int CFG_A_PARITY_RD = 1;
  localparam int CFG_B_FORCE_MISS = 0;
  localparam int CFG_B_FULL_FLUSH = 1;
  localparam int CFG_B_INJECT = 2;
  // debug tag low and high field positions
  localparam int TLO_DIRTY_LSB = 4;
  localparam int TLO_DATA_PARITY_CHECK_FIELD_LSB = 8;
  localparam int TLO_MPAR_LSB = 12;
  localparam int TLO_TPAR_LSB = 16;
  localparam int TLO_UPAR = 18;
  localparam int THI_VALID = 7;
  localparam int THI_ADDR_LSB = 8;
  // state machine
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOOK = 5'b00010,
    ST_WBACK = 5'b00100,
    ST_FILL = 5'b01000,
    ST_FLASH = 5'b10000
  } dcm_state_t;
endpackage

// ### rtl/dcm_wb_sizer.sv
`timescale 1ns/1ps
// picks the write-back transfer size from dirty bits
module dcm_wb_sizer (
  // inputs
  input wire logic [3:0] dirty,
  input wire logic fullFlush,
  // outputs
  output logic [1:0] wbSize,
  output logic [1:0] wbFirst
);
  // smallest covering transfer, or a full line when fullFlush is set
  always_comb begin
    wbFirst = 2'h0;
    if (fullFlush) begin
      wbSize = dcm_pkg::WB_LINE; // RULE16
    end else if (dirty == 4'h1 || dirty == 4'h2 || dirty == 4'h4 || dirty == 4'h8) begin
      wbSize = dcm_pkg::WB_DWORD; // RULE16
      wbFirst = dirty[1] ? 2'h1 : dirty[2] ? 2'h2 : dirty[3] ? 2'h3 : 2'h0;
    end else if (dirty[3:2] == 2'h0 || dirty[1:0] == 2'h0) begin
      wbSize = dcm_pkg::WB_QWORD; // RULE16
      wbFirst = (dirty[1:0] == 2'h0) ? 2'h2 : 2'h0;
    end else begin
      wbSize = dcm_pkg::WB_LINE; // RULE16
    end
  end
endmodule // dcm_wb_sizer

// ### rtl/dcm_parity.sv
`timescale 1ns/1ps
// parity check values for one data word, zero when parity holds and inject is clear
module dcm_parity (
  // data and stored parity
  input wire logic [31:0] word,
  input wire logic [3:0] storedPar,
  input wire logic inject,
  // check result
  output logic [3:0] check
);
  // one check bit per byte
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : gByte
      assign check[b] = (^word[b*8 +: 8]) ^ storedPar[b] ^ inject; // RULE15
    end
  endgenerate
endmodule // dcm_parity

// ### rtl/dcm_maint.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - the cache never snoops; only local operations touch lines and no bus input updates them.
// RULE2 - block allocate completes at once and changes nothing.
// RULE3 - block flush writes back a dirty line then invalidates it.
// RULE4 - block invalidate drops the line without write-back and is privileged only.
// RULE5 - block store writes back a dirty line and leaves it valid and clean.
// RULE6 - touch for store runs exactly as touch.
// RULE7 - zero line allocates without reading memory, fills zeros, marks all doublewords dirty.
// RULE8 - congruence invalidate clears every line at once and is privileged only.
// RULE9 - debug read returns one data word and captures the tag into two debug tag registers.
// RULE10 - by default a touch is dropped when its fill cannot start at once and loads are pending.
// RULE11 - with guaranteed touch set a touch always fills if translation allows reading and caching.
// RULE12 - with forced miss set a touch misses even on a hit and allocates a duplicate line.
// RULE13 - software gives debug read a word-aligned address; otherwise the result is undefined.
// RULE14 - with parity read enabled debug read also loads parity into the low debug tag register.
// RULE15 - the captured data parity field holds check results and is zero without an error.
// RULE16 - write-back asks for a full line when forced, else the smallest covering transfer.
// RULE17 - the debug read index split follows the configured cache size.
module dcm_maint #(
  parameter int LINES = 16,
  parameter int FILL_BUFS = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // operation request from the pipeline
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [31:0] opAddr,
  input wire logic [3:0] opTagExt,
  input wire logic privileged,
  input wire logic xlateReadOk,
  input wire logic cacheInhibit,
  input wire logic accessPending,
  // operation answer
  output logic opDone,
  output logic opDropped,
  output logic privFault,
  output logic [31:0] readData,
  // system bus write-back
  output logic wbReq,
  output logic [35:0] wbAddr,
  output logic [1:0] wbSize,
  output logic [dcm_pkg::LINE_BITS-1:0] wbData,
  input wire logic wbAck,
  // system bus line fill
  output logic fillReq,
  output logic [35:0] fillAddr,
  input wire logic fillAck,
  input wire logic [255:0] fillData,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);
  localparam int IDX_W = $clog2(LINES);
  localparam int WSEL_W = $clog2(dcm_pkg::WORDS_PER_LINE);
  localparam int OFF_W = $clog2(dcm_pkg::LINE_BYTES);

  // line storage
  logic [255:0] lineData [LINES];
  logic [35:0] lineTag [LINES];
  logic [3:0] lineDirty [LINES];
  logic [31:0] lineDpar [LINES];
  logic [LINES-1:0] lineValid;

  dcm_pkg::dcm_state_t state;
  logic [3:0] curOp;
  logic [35:0] curLine;
  logic [IDX_W-1:0] curIdx;
  logic [31:0] cfgAReg;
  logic [31:0] cfgBReg;
  logic [31:0] tagHighReg;
  logic [31:0] tagLowReg;

  // line-aligned real address of the request
  function automatic logic [35:0] lineOf(input logic [3:0] ext, input logic [31:0] a);
    lineOf = {ext, a[31:OFF_W], {OFF_W{1'b0}}};
  endfunction

  // associative lookup
  logic hit;
  logic [IDX_W-1:0] hitIdx;
  always_comb begin
    hit = 1'b0;
    hitIdx = '0;
    for (int i = 0; i < LINES; i++) begin
      if (lineValid[i] && lineTag[i] == curLine && !hit) begin
        hit = 1'b1;
        hitIdx = IDX_W'(i);
      end
    end
  end

  // fill slot: the line's own index, the next one for a forced duplicate
  logic [IDX_W-1:0] allocIdx;
  assign allocIdx = curLine[OFF_W +: IDX_W] + IDX_W'(hit); // RULE12

  // write-back sizing
  logic [1:0] sizeNext;
  logic [1:0] firstDw;
  dcm_wb_sizer uSizer (
    .dirty(lineDirty[hitIdx]),
    .fullFlush(cfgBReg[dcm_pkg::CFG_B_FULL_FLUSH]),
    .wbSize(sizeNext),
    .wbFirst(firstDw)
  );

  // debug read index split from the address, sized by line count
  logic [IDX_W-1:0] dbgIdx;
  logic [WSEL_W-1:0] dbgWord;
  logic [31:0] dbgWordData;
  logic [3:0] dbgCheck;
  assign dbgIdx = opAddr[OFF_W +: IDX_W]; // RULE17
  assign dbgWord = opAddr[2 +: WSEL_W]; // RULE13
  assign dbgWordData = lineData[dbgIdx][dbgWord*32 +: 32];
  dcm_parity uPar (
    .word(dbgWordData),
    .storedPar(lineDpar[dbgIdx][dbgWord*4 +: 4]),
    .inject(cfgBReg[dcm_pkg::CFG_B_INJECT]),
    .check(dbgCheck)
  );

  // high debug tag word: line address, valid bit and extended address
  logic [31:0] tagHighNext;
  always_comb begin
    tagHighNext = 32'h0;
    tagHighNext[31:dcm_pkg::THI_ADDR_LSB] = lineTag[dbgIdx][31:dcm_pkg::THI_ADDR_LSB]; // RULE9
    tagHighNext[dcm_pkg::THI_VALID] = lineValid[dbgIdx]; // RULE9
    tagHighNext[3:0] = lineTag[dbgIdx][35:32]; // RULE9
  end

  // low debug tag word: dirty bits, and parity fields only when enabled
  logic [31:0] tagLowNext;
  always_comb begin
    tagLowNext = 32'h0;
    tagLowNext[dcm_pkg::TLO_DIRTY_LSB +: 4] = lineDirty[dbgIdx]; // RULE9
    if (cfgAReg[dcm_pkg::CFG_A_PARITY_RD]) begin
      tagLowNext[dcm_pkg::TLO_DATA_PARITY_CHECK_FIELD_LSB +: 4] = dbgCheck; // RULE14 RULE15
      tagLowNext[dcm_pkg::TLO_MPAR_LSB] = ^lineDirty[dbgIdx]; // RULE14
    end
  end

  // byte parity of a line, stored on every line write
  function automatic logic [31:0] parOf(input logic [255:0] d);
    for (int i = 0; i < 32; i++) begin
      parOf[i] = ^d[i*8 +: 8];
    end
  endfunction

  // operation sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= dcm_pkg::ST_IDLE;
      curOp <= 4'h0;
      curLine <= 36'h0;
      curIdx <= '0;
      opDone <= 1'b0;
      opDropped <= 1'b0;
      privFault <= 1'b0;
      readData <= 32'h0;
      wbReq <= 1'b0;
      wbAddr <= 36'h0;
      wbSize <= 2'h0;
      wbData <= '0;
      fillReq <= 1'b0;
      fillAddr <= 36'h0;
      lineValid <= '0;
      tagHighReg <= 32'h0;
      tagLowReg <= 32'h0;
    end else begin
      opDone <= 1'b0;
      opDropped <= 1'b0;
      privFault <= 1'b0;
      case (state)
        dcm_pkg::ST_IDLE: begin
          if (opValid) begin
            curOp <= opCode;
            curLine <= lineOf(opTagExt, opAddr);
            case (opCode)
              dcm_pkg::OP_ALLOC: opDone <= 1'b1; // RULE2
              dcm_pkg::OP_INVAL, dcm_pkg::OP_FLASH_INVAL: begin
                if (!privileged) begin
                  privFault <= 1'b1; // RULE4 RULE8
                  opDone <= 1'b1;
                end else if (opCode == dcm_pkg::OP_FLASH_INVAL) begin
                  state <= dcm_pkg::ST_FLASH;
                end else begin
                  state <= dcm_pkg::ST_LOOK;
                end
              end
              dcm_pkg::OP_DEBUG_READ: begin
                if (!privileged) begin
                  privFault <= 1'b1;
                end else begin
                  readData <= dbgWordData; // RULE9
                  tagHighReg <= tagHighNext; // RULE9
                  tagLowReg <= tagLowNext; // RULE14
                end
                opDone <= 1'b1;
              end
              dcm_pkg::OP_TOUCH, dcm_pkg::OP_TOUCH_ST: begin
                // both touch codes take this same path
                if (!xlateReadOk || cacheInhibit) begin // RULE6 RULE11
                  opDone <= 1'b1;
                end else if (accessPending && !cfgAReg[dcm_pkg::CFG_A_GTOUCH]) begin
                  // pending accesses hold the fill buffers, so the fill cannot start now
                  opDropped <= 1'b1; // RULE10
                  opDone <= 1'b1;
                end else begin
                  state <= dcm_pkg::ST_LOOK; // RULE11
                end
              end
              dcm_pkg::OP_FLUSH, dcm_pkg::OP_STORE, dcm_pkg::OP_ZERO: state <= dcm_pkg::ST_LOOK;
              default: opDone <= 1'b1;
            endcase
          end
        end
        dcm_pkg::ST_LOOK: begin
          case (curOp)
            dcm_pkg::OP_FLUSH, dcm_pkg::OP_STORE: begin
              if (hit && lineDirty[hitIdx] != 4'h0) begin
                curIdx <= hitIdx;
                wbReq <= 1'b1; // RULE3 RULE5
                wbSize <= sizeNext; // RULE16
                wbAddr <= curLine | 36'(firstDw) << 3;
                wbData <= lineData[hitIdx];
                state <= dcm_pkg::ST_WBACK;
              end else begin
                if (hit && curOp == dcm_pkg::OP_FLUSH) begin
                  lineValid[hitIdx] <= 1'b0; // RULE3
                end
                opDone <= 1'b1;
                state <= dcm_pkg::ST_IDLE;
              end
            end
            dcm_pkg::OP_INVAL: begin
              if (hit) begin
                lineValid[hitIdx] <= 1'b0; // RULE4
              end
              opDone <= 1'b1;
              state <= dcm_pkg::ST_IDLE;
            end
            dcm_pkg::OP_ZERO: begin
              // a miss takes over its slot; a line held there is not cast out
              curIdx <= hit ? hitIdx : allocIdx;
              lineValid[hit ? hitIdx : allocIdx] <= 1'b1; // RULE7
              opDone <= 1'b1;
              state <= dcm_pkg::ST_IDLE;
            end
            default: begin
              if (hit && !cfgBReg[dcm_pkg::CFG_B_FORCE_MISS]) begin // RULE12
                opDone <= 1'b1;
                state <= dcm_pkg::ST_IDLE;
              end else begin
                curIdx <= allocIdx;
                fillReq <= 1'b1;
                fillAddr <= curLine;
                state <= dcm_pkg::ST_FILL;
              end
            end
          endcase
        end
        dcm_pkg::ST_WBACK: begin
          if (wbAck) begin
            wbReq <= 1'b0;
            lineValid[curIdx] <= (curOp == dcm_pkg::OP_STORE); // RULE3 RULE5
            opDone <= 1'b1;
            state <= dcm_pkg::ST_IDLE;
          end
        end
        dcm_pkg::ST_FILL: begin
          if (fillAck) begin
            fillReq <= 1'b0;
            lineValid[curIdx] <= 1'b1; // RULE12
            opDone <= 1'b1;
            state <= dcm_pkg::ST_IDLE;
          end
        end
        dcm_pkg::ST_FLASH: begin
          lineValid <= '0; // RULE8
          opDone <= 1'b1;
          state <= dcm_pkg::ST_IDLE;
        end
        default: state <= dcm_pkg::ST_IDLE;
      endcase
    end
  end

  // line contents, tags and dirty bits; only local operations write them
  always_ff @(posedge clk) begin
    if (state == dcm_pkg::ST_LOOK && curOp == dcm_pkg::OP_ZERO) begin
      lineData[hit ? hitIdx : allocIdx] <= '0; // RULE7
      lineDpar[hit ? hitIdx : allocIdx] <= 32'h0;
      lineTag[hit ? hitIdx : allocIdx] <= curLine;
      lineDirty[hit ? hitIdx : allocIdx] <= 4'hf; // RULE7
    end else if (state == dcm_pkg::ST_LOOK && curOp == dcm_pkg::OP_INVAL && hit) begin
      lineDirty[hitIdx] <= 4'h0; // RULE4
    end else if (state == dcm_pkg::ST_WBACK && wbAck) begin
      lineDirty[curIdx] <= 4'h0; // RULE5
    end else if (state == dcm_pkg::ST_FILL && fillAck) begin
      lineData[curIdx] <= fillData; // RULE1
      lineDpar[curIdx] <= parOf(fillData);
      lineTag[curIdx] <= curLine;
      lineDirty[curIdx] <= 4'h0;
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfgAReg <= 32'h0;
      cfgBReg <= 32'h0;
    end else if (regWr) begin
      if (regAddr == dcm_pkg::ADDR_CFG_A) begin
        cfgAReg <= regWdata;
      end
      if (regAddr == dcm_pkg::ADDR_CFG_B) begin
        cfgBReg <= regWdata;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        dcm_pkg::ADDR_CFG_A: regRdata <= cfgAReg;
        dcm_pkg::ADDR_CFG_B: regRdata <= cfgBReg;
        dcm_pkg::ADDR_TAG_HIGH: regRdata <= tagHighReg;
        dcm_pkg::ADDR_TAG_LOW: regRdata <= tagLowReg;
        dcm_pkg::ADDR_STATUS: regRdata <= {27'h0, state};
        default: regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end
endmodule // dcm_maint

// ### tb/dcm_maint_properties.sv
`timescale 1ns/1ps
// port-level checks on the maintenance block
module dcm_maint_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pipeline side
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic privileged,
  input wire logic opDone,
  input wire logic opDropped,
  input wire logic privFault,
  // bus side
  input wire logic wbReq,
  input wire logic [35:0] wbAddr,
  input wire logic [1:0] wbSize,
  input wire logic wbAck,
  input wire logic fillReq,
  input wire logic [35:0] fillAddr,
  input wire logic fillAck
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ops that need privilege
  wire logic privOp = opCode == dcm_pkg::OP_INVAL || opCode == dcm_pkg::OP_FLASH_INVAL ||
    opCode == dcm_pkg::OP_DEBUG_READ;
  // two quiet cycles ending in done
  sequence quiet2;
    !wbReq && !fillReq ##1 !wbReq && !fillReq && opDone;
  endsequence
  sequence noFill2;
    !fillReq ##1 !fillReq && opDone;
  endsequence
  alloc_nop_a: assert property (opValid && opCode == dcm_pkg::OP_ALLOC |=> opDone && !wbReq && !fillReq)
    else $error("allocate not a one-cycle no-op");
  inval_no_wb_a: assert property (opValid && privileged && opCode == dcm_pkg::OP_INVAL |=> quiet2)
    else $error("invalidate moved bus traffic");
  priv_refuse_a: assert property (opValid && !privileged && privOp |=> privFault && opDone && !wbReq)
    else $error("unprivileged op not refused");
  flash_quiet_a: assert property (opValid && privileged && opCode == dcm_pkg::OP_FLASH_INVAL |=> quiet2)
    else $error("flash invalidate not done at once");
  zero_no_fill_a: assert property (opValid && opCode == dcm_pkg::OP_ZERO |=> noFill2)
    else $error("zero line read memory");
  wb_hold_a: assert property (wbReq && !wbAck |=> wbReq && $stable(wbAddr) && $stable(wbSize))
    else $error("write-back request changed before ack");
  wb_align_a: assert property (wbReq |-> (wbSize == dcm_pkg::WB_LINE && wbAddr[4:0] == 5'h00) ||
    (wbSize == dcm_pkg::WB_QWORD && wbAddr[3:0] == 4'h0) || (wbSize == dcm_pkg::WB_DWORD && wbAddr[2:0] == 3'h0))
    else $error("write-back size and address disagree");
  fill_hold_a: assert property (fillReq && !fillAck |=> fillReq && $stable(fillAddr))
    else $error("fill request changed before ack");
  drop_done_a: assert property (opDropped |-> opDone && !fillReq)
    else $error("dropped touch still filling");
endmodule // dcm_maint_properties

bind dcm_maint dcm_maint_properties u_props (.clk(clk), .reset(reset), .opValid(opValid), .opCode(opCode),
  .privileged(privileged), .opDone(opDone), .opDropped(opDropped), .privFault(privFault), .wbReq(wbReq),
  .wbAddr(wbAddr), .wbSize(wbSize), .wbAck(wbAck), .fillReq(fillReq), .fillAddr(fillAddr), .fillAck(fillAck));

// ### tb/dcm_bus_model.sv
`timescale 1ns/1ps
// system bus memory: acks after lat cycles, write-back first
module dcm_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // requests and latency
  input wire logic wbReq,
  input wire logic fillReq,
  input wire logic [3:0] lat,
  // answers
  output logic wbAck,
  output logic fillAck,
  output logic [255:0] fillData
);
  logic [3:0] cnt;
  logic [255:0] pat;
  // memory image, word i reads a5a5000i; never pushed into the cache unasked
  always_comb begin
    for (int i = 0; i < 8; i++) pat[i*32 +: 32] = 32'ha5a50000 | i;
  end
  // data valid only with the ack, inverted otherwise
  assign fillData = fillAck ? pat : ~pat;
  // one-cycle acks after the wait
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 4'h0;
      wbAck <= 1'b0;
      fillAck <= 1'b0;
    end else begin
      wbAck <= 1'b0;
      fillAck <= 1'b0;
      if ((wbReq && !wbAck) || (fillReq && !fillAck)) begin
        if (cnt >= lat) begin
          cnt <= 4'h0;
          wbAck <= wbReq;
          fillAck <= !wbReq && fillReq;
        end else cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // dcm_bus_model

// ### tb/tb_dcm_maint.sv
`timescale 1ns/1ps
module tb_dcm_maint;
  logic clk = 0, reset = 1, opValid = 0, privileged = 1, xlateReadOk = 1, cacheInhibit = 0, accessPending = 0;
  logic [3:0] opCode = 0, opTagExt = 0, regAddr = 0, lat = 4'h2;
  logic [31:0] opAddr = 0, regWdata = 0, readData, regRdata, w, hi, lo;
  logic regWr = 0, regRd = 0, opDone, opDropped, privFault, wbReq, wbAck, fillReq, fillAck, pf;
  logic [35:0] wbAddr, fillAddr, wbA, fA;
  logic [1:0] wbSize, wbS;
  logic [255:0] wbData, fillData, wbD;
  int failures = 0, check_count = 0, wbs, fills;
  localparam logic [31:0] LA = 32'h00001040, LB = 32'h00002060, LC = 32'h00003080;
  always #50 clk = ~clk;
  dcm_maint uut (.clk(clk), .reset(reset), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
    .opTagExt(opTagExt), .privileged(privileged), .xlateReadOk(xlateReadOk), .cacheInhibit(cacheInhibit),
    .accessPending(accessPending), .opDone(opDone), .opDropped(opDropped), .privFault(privFault),
    .readData(readData), .wbReq(wbReq), .wbAddr(wbAddr), .wbSize(wbSize), .wbData(wbData), .wbAck(wbAck),
    .fillReq(fillReq), .fillAddr(fillAddr), .fillAck(fillAck), .fillData(fillData), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  dcm_bus_model bus (.clk(clk), .reset(reset), .wbReq(wbReq), .fillReq(fillReq), .lat(lat),
    .wbAck(wbAck), .fillAck(fillAck), .fillData(fillData));
  task chk(input logic [255:0] s, input logic [255:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one op; counts acked transfers until done
  task op(input logic [3:0] c, input logic [31:0] a);
    int i;
    wbs = 0;
    fills = 0;
    pf = 0;
    @(posedge clk);
    opValid <= 1;
    opCode <= c;
    opAddr <= a;
    @(posedge clk);
    opValid <= 0;
    for (i = 0; i < 100; i++) begin
      #1;
      if (wbAck === 1'b1) begin
        wbs++;
        wbD = wbData;
        wbA = wbAddr;
        wbS = wbSize;
      end
      if (fillAck === 1'b1) begin
        fills++;
        fA = fillAddr;
      end
      if (privFault === 1'b1) pf = 1;
      if (opDone === 1'b1) break;
      @(posedge clk);
    end
    if (i == 100) failures++;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1 d = regRdata;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 0;
  endtask
  // debug read of word 3, word-aligned address
  task dbg(input logic [31:0] a);
    op(dcm_pkg::OP_DEBUG_READ, a + 32'hc);
    w = readData;
    rd(dcm_pkg::ADDR_TAG_HIGH, hi);
    rd(dcm_pkg::ADDR_TAG_LOW, lo);
  endtask
  task t_alloc_zero_flush;
    rd(dcm_pkg::ADDR_CFG_B, w);
    chk(w, 0);
    rd(4'hf, w);
    chk(w, 0);
    op(dcm_pkg::OP_ALLOC, LA);
    chk(wbs + fills, 0);
    op(dcm_pkg::OP_ZERO, LA);
    chk(fills, 0);
    dbg(LA);
    chk({w, lo[7:4], hi[7], hi[31:8]}, {32'h0, 4'hf, 1'b1, LA[31:8]});
    chk(lo[11:8], 0);
    op(dcm_pkg::OP_FLUSH, LA);
    chk({wbs[1:0], wbS, wbA}, {2'h1, dcm_pkg::WB_LINE, 4'h0, LA});
    chk(wbD, 0);
    dbg(LA);
    chk(hi[7], 0);
    $display("test alloc_zero_flush done");
  endtask
  task t_store_inval;
    op(dcm_pkg::OP_ZERO, LB);
    op(dcm_pkg::OP_STORE, LB);
    chk(wbs, 1);
    dbg(LB);
    chk({hi[7], lo[7:4]}, {1'b1, 4'h0});
    op(dcm_pkg::OP_STORE, LB);
    chk(wbs, 0);
    op(dcm_pkg::OP_ZERO, LA);
    op(dcm_pkg::OP_INVAL, LA);
    chk(wbs, 0);
    dbg(LA);
    chk(hi[7], 0);
    privileged <= 0;
    op(dcm_pkg::OP_INVAL, LB);
    chk(pf, 1);
    op(dcm_pkg::OP_FLASH_INVAL, LB);
    chk(pf, 1);
    op(dcm_pkg::OP_DEBUG_READ, LB);
    chk(pf, 1);
    privileged <= 1;
    op(dcm_pkg::OP_FLASH_INVAL, LB);
    dbg(LB);
    chk(hi[7], 0);
    $display("test store_inval done");
  endtask
  task t_touch;
    logic [3:0] c;
    for (int k = 0; k < 2; k++) begin
      c = k ? dcm_pkg::OP_TOUCH_ST : dcm_pkg::OP_TOUCH;
      op(dcm_pkg::OP_FLASH_INVAL, LC);
      op(c, LC);
      chk(fills, 1);
      dbg(LC);
      chk(w, 32'ha5a50003);
      op(c, LC);
      chk(fills, 0);
      wr(dcm_pkg::ADDR_CFG_B, 32'h1);
      op(c, LC);
      chk(fills, 1);
      wr(dcm_pkg::ADDR_CFG_B, 32'h0);
    end
    wr(dcm_pkg::ADDR_CFG_A, 32'h1);
    rd(dcm_pkg::ADDR_CFG_A, w);
    chk(w, 1);
    accessPending <= 1;
    op(dcm_pkg::OP_FLASH_INVAL, LC);
    op(dcm_pkg::OP_TOUCH, LC);
    chk({fills, opDropped}, {32'h1, 1'b0});
    chk(fA, {4'h0, LC});
    wr(dcm_pkg::ADDR_CFG_A, 32'h0);
    op(dcm_pkg::OP_FLASH_INVAL, LC);
    op(dcm_pkg::OP_TOUCH, LC);
    chk({fills, opDropped}, {32'h0, 1'b1});
    accessPending <= 0;
    wr(dcm_pkg::ADDR_CFG_B, 32'h4);
    dbg(LC);
    chk(lo[15:8], 0);
    wr(dcm_pkg::ADDR_CFG_B, 32'h0);
    wr(dcm_pkg::ADDR_CFG_A, 32'h2);
    dbg(LC);
    chk(lo[11:8], 0);
    wr(dcm_pkg::ADDR_CFG_B, 32'h4);
    dbg(LC);
    chk(lo[15:8], 8'h0f);
    wr(dcm_pkg::ADDR_CFG_B, 32'h0);
    $display("test touch done");
  endtask
  // watchdog: tests need well under 5000 cycles
  initial begin
    #(100 * 20000);
    failures++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    t_alloc_zero_flush;
    t_store_inval;
    t_touch;
    wrap_up;
  end
endmodule // tb_dcm_maint
